// ### core/mux_irq_status.sv
// control byte, interrupt status and address strap logic of the four-channel mux
`timescale 1ns/10ps
module mux_irq_status
    import mux_irq_pkg::*;
#(
    parameter logic [mux_irq_pkg::ADDR_W-mux_irq_pkg::STRAP_W-1:0] ADDR_BASE =
        mux_irq_pkg::ADDR_BASE_DEF
) (
    // clock, reset, enable
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_CE,
    // pins
    input wire logic [mux_irq_pkg::CH_COUNT-1:0] I_CHAN_IRQ_IN_N,
    input wire logic [mux_irq_pkg::STRAP_W-1:0] I_ADDR_STRAP,
    // control byte access
    input wire mux_irq_pkg::ctrl_req_t I_REQ,
    output mux_irq_pkg::ctrl_rsp_t O_RSP,
    // status
    output logic [mux_irq_pkg::SEL_W-1:0] O_CHAN_SEL,
    output logic [mux_irq_pkg::ADDR_W-1:0] O_SLAVE_ADDR,
    output logic O_IRQ_OUT,
    output logic O_IRQ_OE_N
);
    import mux_irq_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        phase_t phase;
        logic [1:0] settle;
        logic [SEL_W-1:0] sel;
        ctrl_rsp_t rsp;
        logic [STRAP_W-1:0] strap;
        logic irq_oe_n;
    } core_state_t;

    core_state_t st_q;
    core_state_t st_d;
    logic [CH_COUNT-1:0] irq_n_s;
    logic [STRAP_W-1:0] strap_s;

    // ************************************************************
    // parameter checks
    // ************************************************************
    // the byte layout and the two-bit settle counter only serve these constants
    if (IRQ_LSB != SEL_W || CH_COUNT + SEL_W != 8 || SYNC_STAGES > 3) begin
        $error("package constants do not fit the control byte");
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    pin_sync #(.WIDTH(CH_COUNT), .RESET_VAL('1)) u_irq_sync (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_ce(I_CE),
        .i_async(I_CHAN_IRQ_IN_N),
        .o_sync(irq_n_s)
    );

    pin_sync #(.WIDTH(STRAP_W), .RESET_VAL('0)) u_strap_sync (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_ce(I_CE),
        .i_async(I_ADDR_STRAP),
        .o_sync(strap_s)
    );

    // ************************************************************
    // next state
    // ************************************************************
    function automatic logic [7:0] ctrl_byte(input logic [CH_COUNT-1:0] irq_n,
                                             input logic [SEL_W-1:0] sel);
        ctrl_byte = {~irq_n, sel};
    endfunction

    always_comb begin
        st_d = st_q;
        if (I_CE) begin
            st_d.rsp.valid = 1'b0;
            // any low input pulls the shared line, selected or not
            st_d.irq_oe_n = &irq_n_s;
            case (st_q.phase)
                ST_CAPTURE: begin
                    // the strap synchroniser sits in reset too, so wait until both stages
                    // hold the pin level before taking it
                    if (st_q.settle == 2'(SYNC_STAGES)) begin
                        st_d.strap = strap_s;
                        st_d.phase = ST_RUN;
                    end else begin
                        st_d.settle = 2'(st_q.settle + 2'h1);
                    end
                end
                ST_RUN: begin
                    // only the low nibble is writable; the flags ignore writes
                    if (I_REQ.wr) begin
                        st_d.sel = I_REQ.wdata[SEL_W-1:0];
                    end
                    if (I_REQ.rd) begin
                        st_d.rsp.valid = 1'b1;
                        st_d.rsp.rdata = ctrl_byte(irq_n_s, st_q.sel);
                    end
                end
                default: begin
                    st_d.phase = ST_RUN;
                end
            endcase
        end
    end

    // power-on reset is the only path back to the defaults
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_q.phase <= ST_CAPTURE;
            st_q.settle <= '0;
            st_q.sel <= SEL_RESET;
            st_q.rsp <= {1'b0, CTRL_RESET};
            st_q.strap <= '0;
            st_q.irq_oe_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign O_RSP = st_q.rsp;
    assign O_CHAN_SEL = st_q.sel;
    assign O_SLAVE_ADDR = {ADDR_BASE, st_q.strap};
    assign O_IRQ_OUT = 1'b0;
    assign O_IRQ_OE_N = st_q.irq_oe_n;

    // ************************************************************
    // checks
    // ************************************************************
    ch0_status_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && st_q.phase == ST_RUN && I_REQ.rd |=>
            O_RSP.valid && O_RSP.rdata[IRQ_LSB] == !$past(irq_n_s[0]))
        else $error("channel 0 flag wrong");
    ch1_status_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && st_q.phase == ST_RUN && I_REQ.rd |=>
            O_RSP.rdata[IRQ_LSB+1] == !$past(irq_n_s[1]))
        else $error("channel 1 flag wrong");
    ch2_status_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && st_q.phase == ST_RUN && I_REQ.rd |=>
            O_RSP.rdata[IRQ_LSB+2] == !$past(irq_n_s[2]))
        else $error("channel 2 flag wrong");
    ch3_status_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && st_q.phase == ST_RUN && I_REQ.rd |=>
            O_RSP.rdata[IRQ_LSB+3] == !$past(irq_n_s[3]))
        else $error("channel 3 flag wrong");
    flag_nibble_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && st_q.phase == ST_RUN && I_REQ.rd && !I_REQ.wr |=>
            O_RSP.rdata == {~$past(irq_n_s), $past(st_q.sel)})
        else $error("control byte layout wrong");
    reset_default_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        st_q.phase == ST_CAPTURE |-> st_q.sel == SEL_RESET && O_RSP.rdata == CTRL_RESET &&
            !O_RSP.valid && O_IRQ_OE_N)
        else $error("defaults not loaded");
    no_reentry_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        st_q.phase == ST_RUN |=> st_q.phase == ST_RUN)
        else $error("defaults reached without reset");
    strap_addr_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && st_q.phase == ST_CAPTURE && st_q.settle == 2'(SYNC_STAGES) |=>
            O_SLAVE_ADDR[STRAP_W-1:0] == $past(strap_s) ##1 $stable(O_SLAVE_ADDR))
        else $error("strap not captured");
    irq_drive_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && (irq_n_s != '1) |=> !O_IRQ_OE_N && !O_IRQ_OUT)
        else $error("combined interrupt not driven");
    flags_ro_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && st_q.phase == ST_RUN && I_REQ.wr && !I_REQ.rd |=>
            $stable(O_RSP.rdata) && O_CHAN_SEL == $past(I_REQ.wdata[SEL_W-1:0]))
        else $error("write disturbed flags");
    irq_release_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && irq_n_s == '1 |=> O_IRQ_OE_N)
        else $error("combined interrupt held without cause");
    read_pulse_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && !(st_q.phase == ST_RUN && I_REQ.rd) |=> !O_RSP.valid)
        else $error("answer without read");
    sel_hold_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && !I_REQ.wr |=> $stable(O_CHAN_SEL))
        else $error("select changed without write");
    rdata_hold_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && !I_REQ.rd |=> $stable(O_RSP.rdata))
        else $error("read data changed without read");
    capture_wait_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        I_CE && st_q.phase == ST_CAPTURE && st_q.settle != 2'(SYNC_STAGES) |=>
            st_q.phase == ST_CAPTURE && O_SLAVE_ADDR[STRAP_W-1:0] == '0)
        else $error("strap taken before synchroniser settled");
    addr_fixed_a: assert property (
        @(posedge I_CLK) disable iff (!I_RESET_N)
        st_q.phase == ST_RUN |=> $stable(O_SLAVE_ADDR))
        else $error("slave address moved after capture");
endmodule

// ### core/pin_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    // clock, reset and enable
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    // levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    if (WIDTH < 1) begin
        $error("pin_sync width must be at least one");
    end

    // meta is read only by the second stage
    always_comb begin
        st_d = st_q;
        if (i_ce) begin
            st_d.meta = i_async;
            st_d.stable = st_q.meta;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= {RESET_VAL, RESET_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_sync = st_q.stable;
endmodule

// ### inc/mux_irq_pkg.sv
// shared constants and carrier types of the mux interrupt status block
package mux_irq_pkg;
    localparam int CH_COUNT = 4;
    localparam int STRAP_W = 2;
    localparam int ADDR_W = 7;
    localparam int IRQ_LSB = 4;
    localparam int SEL_W = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
    // upper slave address bits are not fixed by the pins; the value is arbitrary
    localparam logic [ADDR_W-STRAP_W-1:0] ADDR_BASE_DEF = 5'h0e;
    localparam int SYNC_STAGES = 2;

    // one access to the control byte, taken in a single cycle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } ctrl_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } ctrl_rsp_t;

    typedef enum logic [1:0] {
        ST_CAPTURE = 2'b01,
        ST_RUN = 2'b10
    } phase_t;
endpackage

// ### verif/mux_irq_status_test.sv
// self-checking bench for the mux interrupt status block
`timescale 1ns/10ps
module mux_irq_status_test;
    import mux_irq_pkg::*;
    logic clk;
    logic reset_n;
    logic ce;
    logic [3:0] pins_n;
    logic [1:0] strap;
    ctrl_req_t req;
    ctrl_rsp_t rsp;
    logic [3:0] sel;
    logic [6:0] addr;
    logic oe_n;
    logic irq_out;
    int err_count;
    int compares;
    mux_irq_status dut_u (.I_CLK(clk), .I_RESET_N(reset_n), .I_CE(ce),
        .I_CHAN_IRQ_IN_N(pins_n), .I_ADDR_STRAP(strap), .I_REQ(req), .O_RSP(rsp),
        .O_CHAN_SEL(sel), .O_SLAVE_ADDR(addr), .O_IRQ_OUT(irq_out), .O_IRQ_OE_N(oe_n));
    mux_master_model master_u (.i_clk(clk), .o_req(req), .i_rsp(rsp));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic results();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic do_reset();
        reset_n = 1'b0;
        step(4);
        reset_n = 1'b1;
        // strap is taken at the third edge after release, requests from the fourth
        step(4);
    endtask
    task automatic read_chk(input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        master_u.rd_byte(d, ok);
        check("rsp_valid", 8'h01, {7'h00, ok});
        check("rdata", exp, d);
        // a lost answer ends the run at once
        if (ok !== 1'b1) results();
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_defaults();
        do_reset();
        check("sel", 8'h00, {4'h0, sel});
        check("irq_oe_n", 8'h01, {7'h00, oe_n});
        check("addr", {1'b0, ADDR_BASE_DEF, 2'b01}, {1'b0, addr});
        read_chk(8'h00);
    endtask
    task automatic t_each();
        for (int n = 0; n < 4; n++) begin
            pins_n = ~(4'h1 << n);
            step(4);
            check("irq_oe_n", 8'h00, {7'h00, oe_n});
            check("irq_out", 8'h00, {7'h00, irq_out});
            read_chk({4'h1 << n, 4'h0});
        end
    endtask
    task automatic t_combo();
        logic [3:0] tbl [4] = '{4'h6, 4'h9, 4'h0, 4'hf};
        foreach (tbl[i]) begin
            pins_n = tbl[i];
            step(4);
            check("irq_oe_n", {7'h00, tbl[i] == 4'hf}, {7'h00, oe_n});
            read_chk({~tbl[i], 4'h0});
        end
    endtask
    task automatic t_write();
        pins_n = 4'ha;
        step(4);
        master_u.wr_byte(8'hf5);
        check("sel", 8'h05, {4'h0, sel});
        read_chk(8'h55);
        ce = 1'b0;
        master_u.wr_byte(8'h03);
        ce = 1'b1;
        check("sel", 8'h05, {4'h0, sel});
    endtask
    task automatic t_reset();
        strap = 2'b10;
        master_u.wr_byte(8'h03);
        step(4);
        check("sel", 8'h03, {4'h0, sel});
        check("addr", {1'b0, ADDR_BASE_DEF, 2'b01}, {1'b0, addr});
        do_reset();
        check("sel", 8'h00, {4'h0, sel});
        check("addr", {1'b0, ADDR_BASE_DEF, 2'b10}, {1'b0, addr});
    endtask
    initial begin
        err_count = 0;
        compares = 0;
        reset_n = 1'b0;
        ce = 1'b1;
        pins_n = 4'hf;
        strap = 2'b01;
        t_defaults();
        t_each();
        t_combo();
        t_write();
        t_reset();
        results();
    end
endmodule

// ### verif/mux_master_model.sv
// upstream master model issuing control byte accesses
`timescale 1ns/10ps
module mux_master_model
    import mux_irq_pkg::*;
(
    // clock
    input wire logic i_clk,
    // access
    output mux_irq_pkg::ctrl_req_t o_req,
    input wire mux_irq_pkg::ctrl_rsp_t i_rsp
);
    initial o_req = '0;
    // each access starts on a fresh edge, so a strobe never drops and rises in one step
    task automatic wr_byte(input logic [7:0] data);
        @(posedge i_clk);
        #1 o_req = '{wr: 1'b1, rd: 1'b0, wdata: data};
        @(posedge i_clk);
        #1 o_req = '0;
    endtask
    task automatic rd_byte(output logic [7:0] data, output logic ok);
        ok = 1'b0;
        data = 8'h00;
        @(posedge i_clk);
        #1 o_req.rd = 1'b1;
        @(posedge i_clk);
        #1 o_req.rd = 1'b0;
        // bounded wait for the one-cycle answer
        repeat (3) begin
            if (!ok && i_rsp.valid === 1'b1) begin
                ok = 1'b1;
                data = i_rsp.rdata;
            end
            if (!ok) @(posedge i_clk) #1;
        end
    endtask
endmodule
